// >>> tpo_pkg.sv
package tpo_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int BUSY_WIDTH_NS   = 320;
  localparam int BUSY_CYC        = (BUSY_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_MIN_NS  = 70;
  localparam int RELEASE_CYC     = (RELEASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARRY_MIN_NS    = 300;
  localparam int CARRY_CYC       = (CARRY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_EDGES    = 2;

  // register map, byte addresses
  localparam int              ADDR_W      = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_POS  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LATCH = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;

  // ctrl fields
  localparam int CTRL_RES_LSB   = 0;
  localparam int CTRL_NARROW    = 2;
  localparam logic [1:0] CTRL_RES_RESET = 2'h1;
  // stat fields
  localparam int STAT_DIR       = 0;
  localparam int STAT_CARRY     = 1;
  localparam int STAT_BUSY      = 2;

  // resolution select codes
  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_14 = 2'h2;
  localparam logic [1:0] RES_16 = 2'h3;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [15:0] POS_ZERO    = 16'h0000;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } lane_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [ADDR_W-1:0] raddr;
  } reg_req_t;

  function automatic logic [15:0] res_mask(input logic [1:0] sel);
    case (sel)
      RES_10:  return 16'h03FF;
      RES_12:  return 16'h0FFF;
      RES_14:  return 16'h3FFF;
      default: return 16'hFFFF;
    endcase
  endfunction

endpackage

// >>> busy_gen.sv
`timescale 1ns/1ps
`default_nettype none
module busy_gen #(
  parameter int WIDTH_CYC = tpo_pkg::BUSY_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pulse request and output
  input  wire logic trigger,
  output logic      busy
);
  import tpo_pkg::*;

  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
  } busy_state_t;

  busy_state_t st_reg;
  busy_state_t st_next;

  always_comb begin
    st_next = st_reg;
    // retrigger restarts the full width, so steps closer than the width share one edge
    // busy width window
    if (trigger) begin
      st_next.busy = 1'b1;
      st_next.cnt  = 8'(WIDTH_CYC - 1);
    end else if (st_reg.cnt != 8'h00) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end else begin
      st_next.busy = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;

endmodule // busy_gen
`default_nettype wire

// >>> axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module axil_slave (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // write address and data
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [tpo_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // read
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [tpo_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // register side
  output tpo_pkg::reg_req_t            req,
  input  wire logic                    wr_ok,
  input  wire logic [31:0]             rd_data,
  input  wire logic                    rd_ok
);
  import tpo_pkg::*;

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic              w_full;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } axil_state_t;

  axil_state_t st_reg;
  axil_state_t st_next;
  logic        do_wr;

  assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_full && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign do_wr         = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;

  always_comb begin
    req.wr    = do_wr;
    req.waddr = st_reg.awaddr;
    req.wdata = st_reg.wdata;
    req.wstrb = st_reg.wstrb;
    req.raddr = s_axi_araddr;
  end

  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_full = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_full = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (do_wr) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_data;
      st_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;

endmodule // axil_slave
`default_nettype wire

// >>> tracking_position_output_port.sv
// Contract
// - data stable within 600 ns of hold
// - one busy pulse per counter step; steps closer than the busy width share one
// - hold blocks only counter-to-latch copy
// - hold release fires busy 70-140 ns later
// - enable high floats pins, low drives
// - lower lane LSB; upper per byte choice
// - unused data lines driven low
// - 8-line mode: MSBs or low nibble
// - carry rises on counter wrap
// - carry at least 300 ns, rises with busy
// - dir change: clear after two stable edges
// - carry and dir ignore hold
// - dir follows loop_up one cycle later, as busy follows step; before data
// - preset loads applied word
// - preset with invert clears high-data bits
// - invert active low, idles inactive
// - new byte stable within 140 ns
// - natural binary word, resolution wide
`timescale 1ns/1ps
`default_nettype none
module tracking_position_output_port #(
  parameter int POS_W = 16
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // tracking loop step
  input  wire logic                       step,
  input  wire logic                       loop_up,
  // host control pins
  input  wire logic                       hold_n,
  input  wire logic                       enable_n,
  input  wire logic                       byte_choice,
  input  wire logic                       preset_n,
  input  wire logic                       invert_n,
  // data lanes, split two-way pins
  input  wire tpo_pkg::lane_t             lane_in,
  output tpo_pkg::lane_t                  lane_out,
  output logic                            lane_oe_n,
  // status pins
  output logic                            busy,
  output logic                            carry,
  output logic                            dir,
  // axi4-lite
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [tpo_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [tpo_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp
);
  import tpo_pkg::*;

  typedef struct packed {
    logic [POS_W-1:0] cnt;
    logic [POS_W-1:0] latch;
    logic             dir;
    logic             carry;
    logic [7:0]       carry_age;
    logic             dir_moved;
    logic [1:0]       stable_edges;
    logic             hold_q;
    logic [3:0]       rel_cnt;
    logic [1:0]       res_sel;
    logic             narrow;
    lane_t            lanes;
    logic             oe_n;
  } port_state_t;

  port_state_t      st_reg;
  port_state_t      st_next;
  reg_req_t         req;
  logic             wr_ok;
  logic             rd_ok;
  logic [31:0]      rd_data;
  logic             step_evt;
  logic             release_fire;
  logic             busy_trig;
  logic [POS_W-1:0] mask;
  logic [POS_W-1:0] preset_word;

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_POS) || (a == ADDR_LATCH) || (a == ADDR_STAT);
  endfunction

  // lane steering from the latched word
  function automatic lane_t lane_mux(input logic [POS_W-1:0] w, input logic sel,
                                     input logic nar);
    lane_t l;
    l = '0;
    if (nar) begin
      // 8-line 12-bit form: only the upper lane carries data
      // narrow byte split
      l.upper = sel ? w[11:4] : {4'h0, w[3:0]};
      l.lower = 8'h00;
    end else begin
      l.lower = w[7:0];
      l.upper = sel ? w[15:8] : w[7:0];
    end
    return l;
  endfunction

  assign mask        = POS_W'(res_mask(st_reg.res_sel));
  assign preset_word = POS_W'({lane_in.upper, lane_in.lower}) & mask;

  assign step_evt     = step && preset_n;
  assign release_fire = (st_reg.rel_cnt == 4'h1);
  assign busy_trig    = step_evt || release_fire;

  busy_gen #(
    .WIDTH_CYC (BUSY_CYC)
  ) u_busy (
    .mclk    (mclk),
    .rst     (rst),
    .trigger (busy_trig),
    .busy    (busy)
  );

  axil_slave u_axil (
    .mclk          (mclk),
    .rst           (rst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .req           (req),
    .wr_ok         (wr_ok),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // register read decode
  assign wr_ok = reg_known(req.waddr);
  assign rd_ok = reg_known(req.raddr);
  always_comb begin
    rd_data = WORD_ZERO;
    case (req.raddr)
      ADDR_CTRL: begin
        rd_data[CTRL_RES_LSB +: 2] = st_reg.res_sel;
        rd_data[CTRL_NARROW]       = st_reg.narrow;
      end
      ADDR_POS:   rd_data[POS_W-1:0] = st_reg.cnt;
      ADDR_LATCH: rd_data[POS_W-1:0] = st_reg.latch;
      ADDR_STAT: begin
        rd_data[STAT_DIR]   = st_reg.dir;
        rd_data[STAT_CARRY] = st_reg.carry;
        rd_data[STAT_BUSY]  = busy;
      end
      default: rd_data = WORD_ZERO;
    endcase
  end

  always_comb begin
    st_next        = st_reg;
    st_next.hold_q = hold_n;

    // control register
    if (req.wr && (req.waddr == ADDR_CTRL) && req.wstrb[0]) begin
      st_next.res_sel = req.wdata[CTRL_RES_LSB +: 2];
      st_next.narrow  = req.wdata[CTRL_NARROW];
      // a narrower width drops bits that no longer exist
      st_next.cnt     = st_reg.cnt & POS_W'(res_mask(req.wdata[CTRL_RES_LSB +: 2]));
    end

    st_next.dir = loop_up;

    if (!preset_n) begin
      // invert floats high when undriven, so plain load is the default
      // invert active low
      if (invert_n) begin
        st_next.cnt = preset_word;
      end else begin
        st_next.cnt = st_reg.cnt & ~preset_word;
      end
    end else if (step) begin
      st_next.cnt = loop_up ? ((st_reg.cnt + POS_W'(1)) & mask)
                            : ((st_reg.cnt - POS_W'(1)) & mask);
      if ((loop_up && st_reg.cnt == mask) || (!loop_up && st_reg.cnt == POS_ZERO)) begin
        st_next.carry        = 1'b1;
        st_next.carry_age    = 8'h00;
        st_next.dir_moved    = 1'b0;
        st_next.stable_edges = 2'h0;
      end
    end

    // carry ageing and release; hold plays no part here
    // carry ignores hold
    if (st_reg.carry && !(step_evt && st_next.carry_age == 8'h00 && st_next.carry)) begin
      if (st_reg.carry_age != 8'hFF) begin
        st_next.carry_age = st_reg.carry_age + 8'h01;
      end
      if (loop_up != st_reg.dir) begin
        st_next.dir_moved    = 1'b1;
        st_next.stable_edges = 2'h0;
      end else if (st_reg.dir_moved && busy_trig && st_reg.stable_edges != 2'h3) begin
        st_next.stable_edges = st_reg.stable_edges + 2'h1;
      end
      if (st_reg.carry_age >= 8'(CARRY_CYC - 1)) begin
        if (!st_reg.dir_moved || st_next.stable_edges >= 2'(STABLE_EDGES)) begin
          st_next.carry = 1'b0;
        end
      end
    end

    // release delay from the hold rising edge
    if (hold_n && !st_reg.hold_q) begin
      st_next.rel_cnt = 4'(RELEASE_CYC);
    end else if (st_reg.rel_cnt != 4'h0) begin
      st_next.rel_cnt = st_reg.rel_cnt - 4'h1;
    end

    // copy only with the busy edge and not while held
    // latch with busy
    if (busy_trig && hold_n) begin
      st_next.latch = st_next.cnt;
    end

    // registered pins: one cycle from byte choice or enable
    // byte change one cycle
    st_next.lanes = lane_mux(st_reg.latch & mask, byte_choice, st_reg.narrow);
    st_next.oe_n  = enable_n;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.hold_q  <= 1'b1;
      st_reg.oe_n    <= 1'b1;
      st_reg.res_sel <= CTRL_RES_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane_out  = st_reg.lanes;
  assign lane_oe_n = st_reg.oe_n;
  assign carry     = st_reg.carry;
  assign dir       = st_reg.dir;

endmodule // tracking_position_output_port
`default_nettype wire

// >>> tpo_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tpo_chk (
  // clock and reset
  input wire logic           mclk,
  input wire logic           rst,
  // pins in
  input wire logic           step,
  input wire logic           loop_up,
  input wire logic           hold_n,
  input wire logic           enable_n,
  input wire logic           byte_choice,
  input wire logic           preset_n,
  // pins out
  input wire tpo_pkg::lane_t lane_out,
  input wire logic           lane_oe_n,
  input wire logic           busy,
  input wire logic           carry,
  input wire logic           dir
);
  import tpo_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  busy_step_a: assert property (step && preset_n |=> busy)
    else $error("busy missing after step");
  busy_width_a: assert property ($rose(busy) |-> busy [*5])
    else $error("busy pulse too short");
  oe_follow_a: assert property (1 |=> lane_oe_n == $past(enable_n))
    else $error("pin drive does not follow enable");
  dir_first_a: assert property (step |=> dir == $past(loop_up))
    else $error("direction not ready with step");
  release_busy_a: assert property (!hold_n ##1 hold_n |-> ##[1:3] busy)
    else $error("no busy after hold release");
  carry_cause_a: assert property ($rose(carry) |-> $past(step))
    else $error("carry rose without a step");
  carry_width_a: assert property ($rose(carry) |-> carry [*8])
    else $error("carry pulse too short");
  // lanes frozen while hold stays low
  hold_freeze_a: assert property (!hold_n [*2] ##0 $stable(byte_choice) |=> $stable(lane_out))
    else $error("latched data moved during hold");

  cover property (step && preset_n);
  cover property ($rose(carry));
  cover property (!hold_n ##1 hold_n);
endmodule  // tpo_chk

bind tracking_position_output_port tpo_chk chk (.mclk, .rst, .step, .loop_up, .hold_n,
  .enable_n, .byte_choice, .preset_n, .lane_out, .lane_oe_n, .busy, .carry, .dir);
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic           mclk,
  // device pins
  input  wire tpo_pkg::lane_t lane_out,
  input  wire logic           lane_oe_n,
  input  wire logic           busy,
  input  wire logic           carry,
  input  wire logic           dir,
  // bench control
  input  wire logic           drive_on,
  input  wire tpo_pkg::lane_t drive_val,
  output tpo_pkg::lane_t      lane_in,
  output logic [7:0]          rev_cnt
);
  import tpo_pkg::*;
  lane_t last;
  logic  busy_q;
  initial begin
    last = '0;
    busy_q = 1'b0;
    rev_cnt = 8'h00;
  end
  // host drives only into floated pins
  always_comb begin
    if (!lane_oe_n) lane_in = lane_out;
    else if (drive_on) lane_in = drive_val;
    else lane_in = ~last;
  end
  // undriven lanes toggle so stale data never looks valid
  always @(posedge mclk) last <= lane_in;
  // carry counted only with a busy rise
  always @(posedge mclk) begin
    busy_q <= busy;
    if (busy && !busy_q && carry) rev_cnt <= dir ? rev_cnt + 8'h01 : rev_cnt - 8'h01;
  end
endmodule  // host_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpo_pkg::*;
  logic        mclk, rst, step, loop_up, hold_n, enable_n, byte_choice, preset_n;
  logic        inv_drive, drive_on, lane_oe_n, busy, carry, dir;
  lane_t       drive_val, lane_in, lane_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  rev_cnt;
  int          error_cnt, check_count;
  tri1         invert_n;
  assign invert_n = inv_drive ? 1'b0 : 1'bz;

  tracking_position_output_port dut (.mclk, .rst, .step, .loop_up, .hold_n, .enable_n,
    .byte_choice, .preset_n, .invert_n, .lane_in, .lane_out, .lane_oe_n, .busy, .carry, .dir,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  host_model host (.mclk, .lane_out, .lane_oe_n, .busy, .carry, .dir, .drive_on, .drive_val,
    .lane_in, .rev_cnt);

  always #20 mclk = ~mclk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task axw(input logic [3:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw || w);
    while (!s_axi_bvalid) @(posedge mclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [3:0] a);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task pos(input logic [31:0] e);
    axr(ADDR_POS);
    chk(d, e);
  endtask
  // float pins, drive word, strobe preset for 120 ns, release
  task preset(input logic [15:0] w, input logic plain);
    @(posedge mclk) enable_n <= 1'b1;
    repeat (2) @(posedge mclk);
    drive_on <= 1'b1;
    drive_val <= w;
    @(posedge mclk) preset_n <= 1'b0;
    inv_drive <= !plain;
    repeat (3) @(posedge mclk);
    preset_n <= 1'b1;
    inv_drive <= 1'b0;
    @(posedge mclk) drive_on <= 1'b0;
    enable_n <= 1'b0;
  endtask
  task do_step(input logic up);
    @(posedge mclk) loop_up <= up;
    @(posedge mclk) step <= 1'b1;
    @(posedge mclk) step <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
  task lanes(input logic bc, input logic [15:0] e);
    @(posedge mclk) byte_choice <= bc;
    repeat (3) @(posedge mclk);
    chk({16'h0000, lane_in}, {16'h0000, e});
  endtask

  initial begin
    {mclk, step, inv_drive, drive_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
    {rst, loop_up, hold_n, enable_n, byte_choice, preset_n} = 6'b111111;
    s_axi_wdata = 32'h0000_0000;
    drive_val = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    enable_n <= 1'b0;
    axr(ADDR_CTRL);
    chk(d, {30'h0, RES_12});
    axr(4'h2);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(ADDR_CTRL, {30'h0, RES_16});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    $display("test registers done");
    preset(16'h0015, 1'b1);
    pos(32'h0000_0015);
    preset(16'h0018, 1'b0);
    pos(32'h0000_0005);
    $display("test preset done");
    preset(16'h12FE, 1'b1);
    do_step(1'b1);
    pos(32'h0000_12FF);
    lanes(1'b1, 16'h12FF);
    lanes(1'b0, 16'hFFFF);
    do_step(1'b0);
    pos(32'h0000_12FE);
    preset(16'hFFFF, 1'b1);
    do_step(1'b1);
    pos(32'h0000_0000);
    chk({24'h0, rev_cnt}, 32'h0000_0001);
    do_step(1'b0);
    pos(32'h0000_FFFF);
    chk({24'h0, rev_cnt}, 32'h0000_0000);
    $display("test stepping done");
    axw(ADDR_CTRL, {30'h0, RES_10});
    preset(16'hFFFE, 1'b1);
    do_step(1'b1);
    pos(32'h0000_03FF);
    lanes(1'b1, 16'h03FF);
    do_step(1'b1);
    chk({24'h0, rev_cnt}, 32'h0000_0001);
    axw(ADDR_CTRL, {29'h0, 1'b1, RES_12});
    preset(16'h0ABB, 1'b1);
    do_step(1'b1);
    lanes(1'b1, 16'hAB00);
    lanes(1'b0, 16'h0C00);
    $display("test resolution done");
    axw(ADDR_CTRL, {30'h0, RES_16});
    preset(16'hFFFE, 1'b1);
    do_step(1'b1);
    @(posedge mclk) hold_n <= 1'b0;
    do_step(1'b1);
    chk({24'h0, rev_cnt}, 32'h0000_0002);
    lanes(1'b1, 16'hFFFF);
    pos(32'h0000_0000);
    axr(ADDR_LATCH);
    chk(d, 32'h0000_FFFF);
    @(posedge mclk) hold_n <= 1'b1;
    repeat (12) @(posedge mclk);
    lanes(1'b1, 16'h0000);
    $display("test hold done");
    preset(16'h0000, 1'b1);
    @(posedge mclk) loop_up <= 1'b0;
    @(posedge mclk) step <= 1'b1;
    @(posedge mclk) step <= 1'b0;
    loop_up <= 1'b1;
    @(posedge mclk) loop_up <= 1'b0;
    repeat (20) @(posedge mclk);
    axr(ADDR_STAT);
    chk(d, 32'h0000_0002);
    do_step(1'b0);
    do_step(1'b0);
    axr(ADDR_STAT);
    chk(d, 32'h0000_0000);
    $display("test direction done");
    report_and_stop;
  end

  initial begin
    repeat (8000) @(posedge mclk);
    error_cnt++;
    report_and_stop;
  end
endmodule  // tb
`default_nettype wire
